// >>> logic/gpio_dual_pkg.sv
// constants shared by the dual gpio port block and its leaf modules
// assumes a 32-bit avalon-mm slave with byte addresses and 8-bit ports
package gpio_dual_pkg;
  // port geometry
  localparam int PORT_W    = 8;          // pins per port
  localparam int NUM_PORTS = 4;          // parallel ports on the device
  localparam int ADDR_W    = 8;          // avalon byte address width
  localparam int SYNC_DEPTH = 2;         // pin synchroniser stages

  // register byte offsets
  localparam logic [7:0] OFS_A_LATCH  = 8'h00;  // first port data latch
  localparam logic [7:0] OFS_A_DIR    = 8'h04;  // first port direction
  localparam logic [7:0] OFS_A_LED    = 8'h08;  // first port led sink enable
  localparam logic [7:0] OFS_B_LATCH  = 8'h0c;  // second port data latch
  localparam logic [7:0] OFS_B_DIR    = 8'h10;  // second port direction
  localparam logic [7:0] OFS_PERIPH   = 8'h14;  // analog select, iic and serial enables
  localparam logic [7:0] OFS_TIMER    = 8'h18;  // timer edge/level selects
  localparam logic [7:0] OFS_C_LATCH  = 8'h1c;  // third port data latch
  localparam logic [7:0] OFS_C_DIR    = 8'h20;  // third port direction
  localparam logic [7:0] OFS_D_LATCH  = 8'h24;  // fourth port data latch
  localparam logic [7:0] OFS_D_DIR    = 8'h28;  // fourth port direction

  // peripheral control field positions
  localparam int ANA_SEL_LSB  = 0;       // analog channel select, 5 bits
  localparam int ANA_SEL_W    = 5;
  localparam int IIC_EN_BIT   = 5;       // iic module enable
  localparam int SCI_EN_BIT   = 6;       // serial interface enable

  // reset values
  localparam logic [7:0] DIR_RESET    = 8'h00;  // all pins inputs
  localparam logic [7:0] LED_RESET    = 8'h00;  // standard drive
  localparam logic [4:0] ANA_SEL_RESET = 5'h1f; // no analog channel
  localparam logic [7:0] TIMER_RESET  = 8'h00;  // timers release pins
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000; // unmapped read value
endpackage : gpio_dual_pkg

// >>> logic/pin_sync.sv
// two-stage synchroniser for a group of asynchronous pin levels
// assumes the pins are levels, not pulses, and change slowly vs clk
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 8  // number of levels synchronised
) (
  input  wire  logic         clk,
  input  wire  logic         reset,
  input  wire  logic [W-1:0] async_in,
  output logic       [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;  // first stage, read only by second stage

  initial
  begin
    if (W < 1) $error("pin_sync width must be positive");
  end

  // two flops, reset to low
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // pin_sync
`default_nettype wire

// >>> logic/gpio_port_bank.sv
// one port: data latches, direction bits, pin sampling and read mix
// assumes write strobes are single-cycle pulses from the bus slave
`timescale 1ns/10ps
`default_nettype none
module gpio_port_bank #(
  parameter int W = 8  // pins in this port
) (
  input  wire  logic         clk,
  input  wire  logic         reset,
  input  wire  logic [W-1:0] pin_in,     // raw pin levels
  input  wire  logic         wr_latch,   // write data latch
  input  wire  logic         wr_dir,     // write direction
  input  wire  logic [W-1:0] wdata,      // write value
  output logic       [W-1:0] latch,      // data latch contents
  output logic       [W-1:0] dir,        // direction, 1 = output
  output logic       [W-1:0] pin_sync,   // synchronised pin levels
  output logic       [W-1:0] readback    // value a data read returns
);
  initial
  begin
    if (W < 1 || W > 8) $error("gpio_port_bank width out of range");
  end

  // pin levels pass two flops before any logic
  pin_sync #(.W(W)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  always_ff @(posedge clk)
  begin
    if (wr_latch) latch <= wdata;
  end

  always_ff @(posedge clk)
  begin
    if (reset) dir <= gpio_dual_pkg::DIR_RESET[W-1:0];
    else if (wr_dir) dir <= wdata;
  end

  // per-pin read mix
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_mix
      // input read shows the pin only
      assign readback[i] = dir[i] ? latch[i] : pin_sync[i];
    end
  endgenerate
endmodule // gpio_port_bank
`default_nettype wire

// >>> logic/gpio_dual.sv
// four 8-bit gpio ports behind an avalon-mm slave with waitrequest
// first port: led sink drive and analog channel release
// second port: iic, serial and timer pin sharing, open-drain low half
// assumes pins are asynchronous and peripherals run on clk
`timescale 1ns/10ps
`default_nettype none
module gpio_dual (
  input  wire  logic        clk,
  input  wire  logic        reset,
  // avalon-mm slave
  input  wire  logic [7:0]  address,
  input  wire  logic        read,
  input  wire  logic        write,
  input  wire  logic [31:0] writedata,
  input  wire  logic [3:0]  byteenable,
  output logic       [31:0] readdata,
  output logic              waitrequest,
  // first port pins
  input  wire  logic [7:0]  pin_in_a,
  output logic       [7:0]  pin_out_a,
  output logic       [7:0]  pin_oe_a,
  output logic       [7:0]  led_sink_a,
  output logic       [7:0]  analog_enable_a,
  // second port pins
  input  wire  logic [7:0]  pin_in_b,
  output logic       [7:0]  pin_out_b,
  output logic       [7:0]  pin_oe_b,
  output logic       [3:0]  schmitt_enable_b,
  // third and fourth port pins
  input  wire  logic [7:0]  pin_in_c,
  output logic       [7:0]  pin_out_c,
  output logic       [7:0]  pin_oe_c,
  input  wire  logic [7:0]  pin_in_d,
  output logic       [7:0]  pin_out_d,
  output logic       [7:0]  pin_oe_d,
  // peripheral side of the shared pins
  input  wire  logic        iic_sda_out,
  input  wire  logic        iic_sda_oe,
  input  wire  logic        iic_scl_out,
  input  wire  logic        iic_scl_oe,
  input  wire  logic        sci_txd,
  input  wire  logic [3:0]  timer_ch_out,
  input  wire  logic [3:0]  timer_ch_oe,
  output logic              iic_sda_in,
  output logic              iic_scl_in,
  output logic              sci_rxd,
  output logic       [3:0]  timer_ch_in,
  // control fields seen by the peripherals
  output logic       [4:0]  analog_channel_select,
  output logic              iic_module_enable,
  output logic              serial_iface_enable,
  output logic       [7:0]  timer_edge_level_select
);
  localparam int W = gpio_dual_pkg::PORT_W;
  // bus decode
  logic        accept;         // request completes this edge
  logic        start;          // first cycle of a request
  logic        wr_ok;          // accepted write, low lane enabled
  logic [7:0]  wd;             // low byte of write data
  logic [7:0]  ofs;            // aligned byte offset
  logic [31:0] read_next;      // read value for the current address

  // register storage
  logic [7:0]  led_reg;        // first port led enables
  logic [4:0]  ana_sel_reg;    // analog channel select
  logic        iic_en_reg;     // iic owns bits 0,1
  logic        sci_en_reg;     // serial owns bits 2,3
  logic [7:0]  timer_sel_reg;  // two bits per timer channel

  // port bank views
  logic [W-1:0] latch_a, dir_a, sync_a, rb_a;
  logic [W-1:0] latch_b, dir_b, sync_b, rb_b;
  logic [W-1:0] latch_c, dir_c, sync_c, rb_c;
  logic [W-1:0] latch_d, dir_d, sync_d, rb_d;

  // pin next values
  logic [7:0] ana_mask;        // one-hot analog selected pin
  logic [7:0] out_a_next, oe_a_next, led_a_next;
  logic [7:0] take_b;          // peripheral owns the pin
  logic [7:0] own_val_b;       // peripheral drive value
  logic [7:0] own_en_b;        // peripheral drive enable
  logic [7:0] val_b, en_b;     // merged value and enable
  logic [7:0] out_b_next, oe_b_next;
  logic [3:0] timer_on;        // timer channel active

  // elaboration check of geometry
  initial
  begin
    if (W != 8) $error("gpio_dual expects eight-bit ports");
    if (gpio_dual_pkg::NUM_PORTS != 4) $error("gpio_dual expects four ports");
  end

  // request handshake: one wait cycle, then accept
  assign start  = (read | write) & waitrequest;
  assign accept = (read | write) & ~waitrequest;
  assign wr_ok  = write & accept & byteenable[0];
  assign wd     = writedata[7:0];
  assign ofs    = {address[7:2], 2'b00};

  // read selection, narrow data in low byte
  assign read_next =
    (ofs == gpio_dual_pkg::OFS_A_LATCH) ? {24'h000000, rb_a} :
    (ofs == gpio_dual_pkg::OFS_A_DIR)   ? {24'h000000, dir_a} :
    (ofs == gpio_dual_pkg::OFS_A_LED)   ? {24'h000000, led_reg} :
    (ofs == gpio_dual_pkg::OFS_B_LATCH) ? {24'h000000, rb_b} :
    (ofs == gpio_dual_pkg::OFS_B_DIR)   ? {24'h000000, dir_b} :
    (ofs == gpio_dual_pkg::OFS_PERIPH)  ?
      {25'h0000000, sci_en_reg, iic_en_reg, ana_sel_reg} :
    (ofs == gpio_dual_pkg::OFS_TIMER)   ? {24'h000000, timer_sel_reg} :
    (ofs == gpio_dual_pkg::OFS_C_LATCH) ? {24'h000000, rb_c} :
    (ofs == gpio_dual_pkg::OFS_C_DIR)   ? {24'h000000, dir_c} :
    (ofs == gpio_dual_pkg::OFS_D_LATCH) ? {24'h000000, rb_d} :
    (ofs == gpio_dual_pkg::OFS_D_DIR)   ? {24'h000000, dir_d} :
    gpio_dual_pkg::UNMAPPED_READ;

  // waitrequest high when idle, low for the accept cycle
  always_ff @(posedge clk)
  begin
    if (reset) waitrequest <= 1'b1;
    else waitrequest <= ~start;
  end

  // read data captured in the wait cycle, stands at accept
  always_ff @(posedge clk)
  begin
    if (reset) readdata <= 32'h00000000;
    else if (start & read) readdata <= read_next;
  end

  gpio_port_bank #(.W(W)) u_bank_a (
    .clk      (clk),
    .reset    (reset),
    .pin_in   (pin_in_a),
    .wr_latch (wr_ok && ofs == gpio_dual_pkg::OFS_A_LATCH),
    .wr_dir   (wr_ok && ofs == gpio_dual_pkg::OFS_A_DIR),
    .wdata    (wd),
    .latch    (latch_a),
    .dir      (dir_a),
    .pin_sync (sync_a),
    .readback (rb_a)
  );
  gpio_port_bank #(.W(W)) u_bank_b (
    .clk      (clk),
    .reset    (reset),
    .pin_in   (pin_in_b),
    .wr_latch (wr_ok && ofs == gpio_dual_pkg::OFS_B_LATCH),
    .wr_dir   (wr_ok && ofs == gpio_dual_pkg::OFS_B_DIR),
    .wdata    (wd),
    .latch    (latch_b),
    .dir      (dir_b),
    .pin_sync (sync_b),
    .readback (rb_b)
  );
  gpio_port_bank #(.W(W)) u_bank_c (
    .clk      (clk),
    .reset    (reset),
    .pin_in   (pin_in_c),
    .wr_latch (wr_ok && ofs == gpio_dual_pkg::OFS_C_LATCH),
    .wr_dir   (wr_ok && ofs == gpio_dual_pkg::OFS_C_DIR),
    .wdata    (wd),
    .latch    (latch_c),
    .dir      (dir_c),
    .pin_sync (sync_c),
    .readback (rb_c)
  );
  gpio_port_bank #(.W(W)) u_bank_d (
    .clk      (clk),
    .reset    (reset),
    .pin_in   (pin_in_d),
    .wr_latch (wr_ok && ofs == gpio_dual_pkg::OFS_D_LATCH),
    .wr_dir   (wr_ok && ofs == gpio_dual_pkg::OFS_D_DIR),
    .wdata    (wd),
    .latch    (latch_d),
    .dir      (dir_d),
    .pin_sync (sync_d),
    .readback (rb_d)
  );

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      led_reg       <= gpio_dual_pkg::LED_RESET;
      ana_sel_reg   <= gpio_dual_pkg::ANA_SEL_RESET;
      iic_en_reg    <= 1'b0;
      sci_en_reg    <= 1'b0;
      timer_sel_reg <= gpio_dual_pkg::TIMER_RESET;
    end
    else if (wr_ok)
    begin
      if (ofs == gpio_dual_pkg::OFS_A_LED) led_reg <= wd;
      if (ofs == gpio_dual_pkg::OFS_PERIPH)
      begin
        ana_sel_reg <= wd[gpio_dual_pkg::ANA_SEL_LSB +: gpio_dual_pkg::ANA_SEL_W];
        iic_en_reg  <= wd[gpio_dual_pkg::IIC_EN_BIT];
        sci_en_reg  <= wd[gpio_dual_pkg::SCI_EN_BIT];
      end
      if (ofs == gpio_dual_pkg::OFS_TIMER) timer_sel_reg <= wd;
    end
  end

  // first port and timer-active per-pin terms
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_port_a
      assign ana_mask[i]   = (ana_sel_reg == 5'(i));
      assign oe_a_next[i]  = dir_a[i] & ~ana_mask[i];
      assign out_a_next[i] = latch_a[i] & oe_a_next[i];
      assign led_a_next[i] = led_reg[i] & oe_a_next[i];
    end
    for (i = 0; i < 4; i++)
    begin : g_timer
      assign timer_on[i] = (timer_sel_reg[2*i +: 2] != 2'b00);
    end
  endgenerate

  // second port ownership
  // iic takes bits 0,1
  assign take_b    = {timer_on, sci_en_reg, sci_en_reg, iic_en_reg, iic_en_reg};
  assign own_val_b = {timer_ch_out, 1'b1, sci_txd, iic_scl_out, iic_sda_out};
  assign own_en_b  = {timer_ch_oe, 1'b0, 1'b1, iic_scl_oe, iic_sda_oe};

  generate
    for (i = 0; i < W; i++)
    begin : g_port_b
      // latch and direction resume on release
      assign val_b[i] = take_b[i] ? own_val_b[i] : latch_b[i];
      assign en_b[i]  = take_b[i] ? own_en_b[i] : dir_b[i];
      if (i < 4)
      begin : g_od
        assign out_b_next[i] = 1'b0;
        assign oe_b_next[i]  = en_b[i] & ~val_b[i];
      end
      else
      begin : g_pp
        assign out_b_next[i] = val_b[i] & en_b[i];
        assign oe_b_next[i]  = en_b[i];
      end
    end
  endgenerate

  // registered pin outputs, all ports
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_out_a       <= 8'h00;
      pin_oe_a        <= 8'h00;
      led_sink_a      <= 8'h00;
      analog_enable_a <= 8'h00;
      pin_out_b       <= 8'h00;
      pin_oe_b        <= 8'h00;
      pin_out_c       <= 8'h00;
      pin_oe_c        <= 8'h00;
      pin_out_d       <= 8'h00;
      pin_oe_d        <= 8'h00;
    end
    else
    begin
      pin_out_a       <= out_a_next;
      pin_oe_a        <= oe_a_next;
      led_sink_a      <= led_a_next;
      analog_enable_a <= ana_mask;
      pin_out_b       <= out_b_next;
      pin_oe_b        <= oe_b_next;
      pin_out_c       <= latch_c & dir_c;
      pin_oe_c        <= dir_c;
      pin_out_d       <= latch_d & dir_d;
      pin_oe_d        <= dir_d;
    end
  end

  // peripheral inputs and schmitt buffer enables
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      iic_sda_in       <= 1'b1;
      iic_scl_in       <= 1'b1;
      sci_rxd          <= 1'b1;
      timer_ch_in      <= 4'h0;
      schmitt_enable_b <= 4'hf;
    end
    else
    begin
      iic_sda_in       <= sync_b[0];
      iic_scl_in       <= sync_b[1];
      sci_rxd          <= sync_b[3];
      timer_ch_in      <= sync_b[7:4];
      schmitt_enable_b <= ~oe_b_next[7:4];
    end
  end

  // control fields mirrored out to peripherals
  assign analog_channel_select   = ana_sel_reg;
  assign iic_module_enable       = iic_en_reg;
  assign serial_iface_enable     = sci_en_reg;
  assign timer_edge_level_select = timer_sel_reg;
  // checks
  AST_DIR_RESET: assert property (@(posedge clk)
    reset |=> (dir_a == 8'h00 && dir_b == 8'h00 && dir_c == 8'h00 && dir_d == 8'h00))
    else $error("direction not cleared by reset");
  AST_OE_FOLLOWS_DIR: assert property (@(posedge clk) disable iff (reset)
    ##1 (pin_oe_c == $past(dir_c) && pin_oe_d == $past(dir_d)))
    else $error("output enable does not follow direction");
  AST_WRITE_LATCH: assert property (@(posedge clk) disable iff (reset)
    (wr_ok && ofs == gpio_dual_pkg::OFS_C_LATCH) |=> (latch_c == $past(writedata[7:0])))
    else $error("latch not loaded by write");
  AST_READ_MIX: assert property (@(posedge clk) disable iff (reset)
    (start && read && ofs == gpio_dual_pkg::OFS_C_LATCH)
      |=> (readdata[7:0] == (($past(dir_c) & $past(latch_c)) | (~$past(dir_c) & $past(sync_c)))))
    else $error("port read mix wrong");
  AST_ANALOG_RELEASE: assert property (@(posedge clk) disable iff (reset)
    ##1 ((pin_oe_a & analog_enable_a) == 8'h00))
    else $error("analog pin still driven");
  AST_LED_SINK: assert property (@(posedge clk) disable iff (reset)
    ##1 (led_sink_a == ($past(led_reg) & $past(dir_a) & ~$past(ana_mask))))
    else $error("led sink wrong");
  AST_IIC_TAKE: assert property (@(posedge clk) disable iff (reset)
    iic_en_reg |=> (pin_oe_b[0] == ($past(iic_sda_oe) & ~$past(iic_sda_out))))
    else $error("iic does not own data pin");
  AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (reset)
    pin_out_b[3:0] == 4'h0)
    else $error("open-drain pin driven high");
  AST_ONE_WAIT: assert property (@(posedge clk) disable iff (reset)
    (start && !(read && write)) |=> (!waitrequest ##1 waitrequest))
    else $error("bus answer timing wrong");

  COV_READ_PIN: cover property (@(posedge clk) disable iff (reset)
    accept && read && ofs == gpio_dual_pkg::OFS_A_LATCH && dir_a != 8'hff);
  COV_IIC_OWN: cover property (@(posedge clk) disable iff (reset)
    iic_en_reg && dir_b[0]);
  COV_TIMER_OWN: cover property (@(posedge clk) disable iff (reset)
    timer_on == 4'hf);
endmodule // gpio_dual
`default_nettype wire

// >>> bench/gpio_pin_model.sv
// board model for the first two ports: pin levels seen by the block
// assumes port b bits 0-3 carry external pull-ups, other pins a source
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_model (
  input  wire logic [7:0] pin_out_a,  // block drive value, port a
  input  wire logic [7:0] pin_oe_a,   // block drive enable, port a
  input  wire logic [7:0] pin_out_b,  // block drive value, port b
  input  wire logic [7:0] pin_oe_b,   // block drive enable, port b
  input  wire logic [7:0] ext_a,      // board source level, port a
  input  wire logic [7:0] ext_b,      // board source level, port b
  output logic      [7:0] pin_in_a,   // resolved pin level, port a
  output logic      [7:0] pin_in_b    // resolved pin level, port b
);
  // driven pins follow the block, released pins follow the board
  assign pin_in_a = (pin_oe_a & pin_out_a) | (~pin_oe_a & ext_a);
  assign pin_in_b[3:0] = ~pin_oe_b[3:0];
  assign pin_in_b[7:4] = (pin_oe_b[7:4] & pin_out_b[7:4]) | (~pin_oe_b[7:4] & ext_b[7:4]);
endmodule // gpio_pin_model
`default_nettype wire

// >>> bench/gpio_dual_tb_top.sv
// self-checking bench for the dual gpio block over avalon-mm
// assumes the pin model in gpio_pin_model.sv closes the pin loop for ports a and b; ports c and d read ext_c and ext_d directly
`timescale 1ns/10ps
`default_nettype none
module gpio_dual_tb_top;
  logic clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0, readdata;
  logic [3:0] byteenable = 4'h1, tm_out = 4'h0, tm_oe = 4'h0, schm, tm_in;
  logic waitrequest, sda_o = 1'b0, sda_e = 1'b0, scl_o = 1'b0, scl_e = 1'b0, txd = 1'b0;
  logic sda_i, scl_i, rxd;
  logic [7:0] ext_a = 8'h5a, ext_b = 8'h30, pia, pib, poa, pea, pob, peb, led, ana, q;
  logic [7:0] ext_c = 8'h3c, ext_d = 8'hc3, poc, pec, pod, ped, tsel;
  logic [4:0] ach;
  logic ien, sen;
  int miscompares = 0, cmp_count = 0;
  // clock, 8 ns period
  always #4 clk = ~clk;
  gpio_dual u_gpio_dual (.clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pin_in_a(pia), .pin_out_a(poa), .pin_oe_a(pea),
    .led_sink_a(led), .analog_enable_a(ana), .pin_in_b(pib), .pin_out_b(pob),
    .pin_oe_b(peb), .schmitt_enable_b(schm), .pin_in_c(ext_c), .pin_out_c(poc),
    .pin_oe_c(pec), .pin_in_d(ext_d), .pin_out_d(pod), .pin_oe_d(ped), .iic_sda_out(sda_o),
    .iic_sda_oe(sda_e), .iic_scl_out(scl_o), .iic_scl_oe(scl_e), .sci_txd(txd),
    .timer_ch_out(tm_out), .timer_ch_oe(tm_oe), .iic_sda_in(sda_i), .iic_scl_in(scl_i),
    .sci_rxd(rxd), .timer_ch_in(tm_in), .analog_channel_select(ach),
    .iic_module_enable(ien), .serial_iface_enable(sen), .timer_edge_level_select(tsel));
  gpio_pin_model u_gpio_pin_model (.pin_out_a(poa), .pin_oe_a(pea), .pin_out_b(pob),
    .pin_oe_b(peb), .ext_a(ext_a), .ext_b(ext_b), .pin_in_a(pia), .pin_in_b(pib));
  // counts and verdict, the single exit
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one comparison
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one avalon transfer, held until waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h0, d};
    read <= ~wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (waitrequest !== 1'b0)
    begin
      miscompares++;
      give_verdict();
    end
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  // let registered pin outputs and synchronisers settle
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(0, gpio_dual_pkg::OFS_A_DIR, 8'h00);
    check("dir_a", q, 8'h00);
    bus(0, gpio_dual_pkg::OFS_PERIPH, 8'h00);
    check("periph", q, 8'h1f);
    check("schmitt", {4'h0, schm}, 8'h0f);
    bus(0, 8'h3c, 8'h00);
    check("unmapped", q, 8'h00);
    $display("test reset done");
    bus(1, gpio_dual_pkg::OFS_A_LATCH, 8'hc3);
    bus(0, gpio_dual_pkg::OFS_A_LATCH, 8'h00);
    check("read_a_in", q, 8'h5a);
    bus(1, gpio_dual_pkg::OFS_A_DIR, 8'hf0);
    bus(1, gpio_dual_pkg::OFS_A_LED, 8'hff);
    // low byte lane off: write answered but ignored
    byteenable <= 4'he;
    bus(1, gpio_dual_pkg::OFS_A_LED, 8'h00);
    byteenable <= 4'h1;
    settle();
    bus(0, gpio_dual_pkg::OFS_A_LED, 8'h00);
    check("led_kept", q, 8'hff);
    bus(0, gpio_dual_pkg::OFS_A_LATCH, 8'h00);
    check("read_a_mix", q, 8'hca);
    check("oe_a", pea, 8'hf0);
    check("out_a", poa, 8'hc0);
    check("led_a", led, 8'hf0);
    bus(1, gpio_dual_pkg::OFS_PERIPH, 8'h04);
    settle();
    check("ana_a", ana, 8'h10);
    check("oe_a_ana", pea, 8'he0);
    check("led_a_ana", led, 8'he0);
    $display("test port a done");
    bus(1, gpio_dual_pkg::OFS_B_LATCH, 8'ha5);
    bus(1, gpio_dual_pkg::OFS_B_DIR, 8'hff);
    settle();
    check("oe_b", peb, 8'hfa);
    check("out_b", pob, 8'ha0);
    check("schmitt_drv", {4'h0, schm}, 8'h00);
    sda_e <= 1'b1;
    txd <= 1'b1;
    tm_oe <= 4'h1;
    tm_out <= 4'h1;
    bus(1, gpio_dual_pkg::OFS_PERIPH, 8'h64);
    bus(1, gpio_dual_pkg::OFS_TIMER, 8'h01);
    settle();
    check("oe_b_own", peb, 8'hf1);
    check("out_b_own", pob, 8'hb0);
    check("iic_in", {5'h0, rxd, scl_i, sda_i}, 8'h06);
    check("tm_in", {4'h0, tm_in}, 8'h0b);
    check("ctl_out", {1'b0, sen, ien, ach}, 8'h64);
    check("tsel", tsel, 8'h01);
    bus(0, gpio_dual_pkg::OFS_B_DIR, 8'h00);
    check("dir_b_own", q, 8'hff);
    bus(0, gpio_dual_pkg::OFS_B_LATCH, 8'h00);
    check("lat_b_own", q, 8'ha5);
    bus(1, gpio_dual_pkg::OFS_PERIPH, 8'h1f);
    bus(1, gpio_dual_pkg::OFS_TIMER, 8'h00);
    settle();
    check("oe_b_free", peb, 8'hfa);
    $display("test port b done");
    bus(1, gpio_dual_pkg::OFS_C_LATCH, 8'h96);
    bus(0, gpio_dual_pkg::OFS_C_LATCH, 8'h00);
    check("read_c_in", q, 8'h3c);
    bus(1, gpio_dual_pkg::OFS_C_DIR, 8'h0f);
    settle();
    bus(0, gpio_dual_pkg::OFS_C_LATCH, 8'h00);
    check("read_c_mix", q, 8'h36);
    check("oe_c", pec, 8'h0f);
    check("out_c", poc, 8'h06);
    bus(1, gpio_dual_pkg::OFS_D_LATCH, 8'h81);
    bus(0, gpio_dual_pkg::OFS_D_LATCH, 8'h00);
    check("read_d_in", q, 8'hc3);
    bus(1, gpio_dual_pkg::OFS_D_DIR, 8'hff);
    settle();
    bus(0, gpio_dual_pkg::OFS_D_DIR, 8'h00);
    check("dir_d", q, 8'hff);
    bus(0, gpio_dual_pkg::OFS_D_LATCH, 8'h00);
    check("read_d", q, 8'h81);
    check("oe_d", ped, 8'hff);
    check("out_d", pod, 8'h81);
    $display("test ports c and d done");
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("oe_a_rst", pea, 8'h00);
    check("oe_c_rst", pec, 8'h00);
    bus(1, gpio_dual_pkg::OFS_A_DIR, 8'hff);
    bus(0, gpio_dual_pkg::OFS_A_LATCH, 8'h00);
    check("lat_a_kept", q, 8'hc3);
    $display("test reset keep done");
    give_verdict();
  end
  // hang guard
  initial
  begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule // gpio_dual_tb_top
`default_nettype wire
